// *** ptmr_defines.svh ***
`ifndef PTMR_DEFINES_SVH
`define PTMR_DEFINES_SVH
// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define PTMR_IDX_INTEN 10'h00B
`define PTMR_IDX_FLAGS 10'h00C
`define PTMR_IDX_COUNT 10'h011
`define PTMR_IDX_CTL 10'h012
`define PTMR_IDX_IE 10'h08C
`define PTMR_IDX_PERIOD 10'h092
// ****************************************
// Field positions
// ****************************************
`define PTMR_POST_MSB 6
`define PTMR_POST_LSB 3
`define PTMR_RUN_BIT 2
`define PTMR_PRE_MSB 1
`define PTMR_PRE_LSB 0
`define PTMR_CTL_TOP_BIT 7
`define PTMR_FLAG_BIT 1
`define PTMR_GIE_BIT 7
`define PTMR_PERIPHERAL_INTERRUPT_ENABLE_BIT 6
// ****************************************
// Reset values and counts
// ****************************************
`define PTMR_PERIOD_RST 8'hFF
`define PTMR_QDIV_LAST 2'h3
`define PTMR_PRE1_LAST 4'h0
`define PTMR_PRE4_LAST 4'h3
`define PTMR_PRE16_LAST 4'hF
`define PTMR_RESP_OKAY 2'h0
`define PTMR_RESP_SLVERR 2'h2
`endif

// *** ptmr_pkg.sv ***
package ptmr_pkg;
    // ****************************************
    // State of the prescaler
    // ****************************************
    typedef struct packed {
        logic [1:0] q_cnt; // Quarter-rate divider
        logic [3:0] cnt;   // Prescale counter
        logic tick;        // Prescaled tick pulse
    } ptmr_presc_t;
    // ****************************************
    // State of the postscaler
    // ****************************************
    typedef struct packed {
        logic [3:0] cnt; // Match counter
        logic tick;      // Postscaled event pulse
    } ptmr_post_t;
    // ****************************************
    // State of the top block
    // ****************************************
    typedef struct packed {
        logic aw_got;       // Write address held
        logic [9:0] aw_idx; // Held write index
        logic w_got;        // Write data held
        logic [7:0] wdata;  // Held write byte
        logic wlane;        // Low byte lane enabled
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic rd_ctl;       // Last read hit control
        logic [6:0] ctl;    // Control, top bit absent
        logic [7:0] count;  // Timer count
        logic [7:0] period; // Timer period
        logic flag;         // Match interrupt flag
        logic ie;           // Match interrupt enable
        logic peripheral_interrupt_enable;         // Peripheral enable
        logic global_interrupt_enable;          // Global enable
        logic ssp_tick;     // Raw match to serial port
        logic irq;          // Interrupt request
    } ptmr_main_t;
endpackage

// *** ptmr_scale_if.sv ***
`timescale 1ns/1ns
// ****************************************
// Link between the timer and a scaler
// ****************************************
interface ptmr_scale_if;
    logic en;        // Input event qualifier
    logic clr;       // Clear the scaler counter
    logic [3:0] sel; // Ratio select
    logic tick;      // Scaled output pulse
    modport ctrl (output en, output clr, output sel, input tick);
    modport div (input en, input clr, input sel, output tick);
endinterface

// *** ptmr_presc.sv ***
`timescale 1ns/1ns
`include "ptmr_defines.svh"
module ptmr_presc
    import ptmr_pkg::*;
(
    input wire logic aclk,    // Device clock
    input wire logic aresetn, // Sync reset, active low
    ptmr_scale_if.div sc      // Control from the timer
);
    ptmr_presc_t st_r; // Registered state
    ptmr_presc_t st_nxt; // Next state
    logic qtick; // Instruction-rate enable
    logic [3:0] last; // Final count for ratio
    assign sc.tick = st_r.tick;
    // ****************************************
    // Quarter divider and prescale counter
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        qtick = (st_r.q_cnt == `PTMR_QDIV_LAST);
        st_nxt.q_cnt = st_r.q_cnt + 2'h1;
        // Upper code bit alone picks 1:16
        if (sc.sel[`PTMR_PRE_MSB]) begin
            last = `PTMR_PRE16_LAST;
        end else if (sc.sel[`PTMR_PRE_LSB]) begin
            last = `PTMR_PRE4_LAST;
        end else begin
            last = `PTMR_PRE1_LAST;
        end
        // Clear beats any pending tick
        if (sc.clr) begin
            st_nxt.cnt = '0;
        end else if (qtick && sc.en) begin
            if (st_r.cnt >= last) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
        end
    end
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_presc_ratio;
        st_r.tick |-> $past(qtick && sc.en && !sc.clr && st_r.cnt >= last);
    endproperty
    a_presc_ratio: assert property (p_presc_ratio)
        else $error("prescaled tick without a full ratio");
endmodule

// *** ptmr_post.sv ***
`timescale 1ns/1ns
`include "ptmr_defines.svh"
module ptmr_post
    import ptmr_pkg::*;
(
    input wire logic aclk,    // Device clock
    input wire logic aresetn, // Sync reset, active low
    ptmr_scale_if.div sc      // Control from the timer
);
    ptmr_post_t st_r; // Registered state
    ptmr_post_t st_nxt; // Next state
    assign sc.tick = st_r.tick;
    // ****************************************
    // Postscale counter, ratio is code plus one
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (sc.clr) begin
            st_nxt.cnt = '0;
        end else if (sc.en) begin
            // Ratio change mid-count takes effect at once
            if (st_r.cnt >= sc.sel) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
        end
    end
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_post_ratio;
        st_r.tick |-> $past(sc.en && !sc.clr && st_r.cnt >= sc.sel);
    endproperty
    a_post_ratio: assert property (p_post_ratio)
        else $error("postscaled event without a full ratio");
    property p_post_clear;
        sc.clr |=> st_r.cnt == 4'h0 && !st_r.tick;
    endproperty
    a_post_clear: assert property (p_post_clear)
        else $error("postscaler not cleared");
endmodule

// *** ptmr_top.sv ***
`timescale 1ns/1ns
`include "ptmr_defines.svh"
module ptmr_top
    import ptmr_pkg::*;
(
    input wire logic aclk,                 // Device clock, 50 MHz
    input wire logic aresetn,              // Sync reset, active low
    input wire logic [11:0] s_axi_awaddr,  // Write address
    input wire logic s_axi_awvalid,        // Write address valid
    output logic s_axi_awready,            // Write address ready
    input wire logic [31:0] s_axi_wdata,   // Write data
    input wire logic [3:0] s_axi_wstrb,    // Write strobes
    input wire logic s_axi_wvalid,         // Write data valid
    output logic s_axi_wready,             // Write data ready
    output logic [1:0] s_axi_bresp,        // Write response
    output logic s_axi_bvalid,             // Write response valid
    input wire logic s_axi_bready,         // Write response ready
    input wire logic [11:0] s_axi_araddr,  // Read address
    input wire logic s_axi_arvalid,        // Read address valid
    output logic s_axi_arready,            // Read address ready
    output logic [31:0] s_axi_rdata,       // Read data
    output logic [1:0] s_axi_rresp,        // Read response
    output logic s_axi_rvalid,             // Read data valid
    input wire logic s_axi_rready,         // Read data ready
    output logic ssp_shift_tick,           // Raw match pulse
    output logic irq_req                   // Interrupt request
);
    // ****************************************
    // Declarations
    // ****************************************
    ptmr_main_t st_r; // Registered state
    ptmr_main_t st_nxt; // Next state
    ptmr_scale_if pre_if (); // Prescaler link
    ptmr_scale_if post_if (); // Postscaler link
    logic wr_go; // Held write executes now
    logic ctl_wr; // Control byte written
    logic cnt_wr; // Count byte written
    logic inc; // Timer advances this cycle
    logic [9:0] ar_idx; // Read index
    // ****************************************
    // Scalers
    // ****************************************
    ptmr_presc u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .sc(pre_if.div)
    );
    ptmr_post u_post (
        .aclk(aclk),
        .aresetn(aresetn),
        .sc(post_if.div)
    );
    // Prescale counter only moves while the timer runs; the quarter divider runs always
    assign pre_if.en = st_r.ctl[`PTMR_RUN_BIT];
    assign pre_if.clr = ctl_wr || cnt_wr;
    assign pre_if.sel = {2'h0, st_r.ctl[`PTMR_PRE_MSB:`PTMR_PRE_LSB]};
    // Postscaler counts raw matches
    assign post_if.en = st_r.ssp_tick;
    assign post_if.clr = ctl_wr || cnt_wr;
    assign post_if.sel = st_r.ctl[`PTMR_POST_MSB:`PTMR_POST_LSB];
    assign ar_idx = s_axi_araddr[11:2];
    // ****************************************
    // Outputs, all from flip-flops
    // ****************************************
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign ssp_shift_tick = st_r.ssp_tick;
    assign irq_req = st_r.irq;
    // ****************************************
    // Bus slave, timer and flags
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.ssp_tick = 1'b0;
        wr_go = 1'b0;
        ctl_wr = 1'b0;
        cnt_wr = 1'b0;
        inc = 1'b0;
        // Address and data may come in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wlane = s_axi_wstrb[0];
        end
        // Both halves held: perform the write
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_go = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `PTMR_RESP_OKAY;
            if (st_r.aw_idx == `PTMR_IDX_FLAGS) begin
                st_nxt.flag = st_r.wlane ? st_r.wdata[`PTMR_FLAG_BIT] : st_r.flag;
            end else if (st_r.aw_idx == `PTMR_IDX_COUNT) begin
                cnt_wr = st_r.wlane;
            end else if (st_r.aw_idx == `PTMR_IDX_CTL) begin
                ctl_wr = st_r.wlane;
            end else if (st_r.aw_idx == `PTMR_IDX_IE) begin
                st_nxt.ie = st_r.wlane ? st_r.wdata[`PTMR_FLAG_BIT] : st_r.ie;
            end else if (st_r.aw_idx == `PTMR_IDX_PERIOD) begin
                st_nxt.period = st_r.wlane ? st_r.wdata : st_r.period;
            end else if (st_r.aw_idx == `PTMR_IDX_INTEN) begin
                st_nxt.global_interrupt_enable = st_r.wlane ? st_r.wdata[`PTMR_GIE_BIT] : st_r.global_interrupt_enable;
                st_nxt.peripheral_interrupt_enable = st_r.wlane ? st_r.wdata[`PTMR_PERIPHERAL_INTERRUPT_ENABLE_BIT] : st_r.peripheral_interrupt_enable;
            end else begin
                // Unmapped: no effect, error answer
                st_nxt.bresp = `PTMR_RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // Read: data sampled from the state before the edge
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `PTMR_RESP_OKAY;
            st_nxt.rdata = 8'h00;
            st_nxt.rd_ctl = 1'b0;
            if (ar_idx == `PTMR_IDX_FLAGS) begin
                st_nxt.rdata[`PTMR_FLAG_BIT] = st_r.flag;
            end else if (ar_idx == `PTMR_IDX_COUNT) begin
                st_nxt.rdata = st_r.count;
            end else if (ar_idx == `PTMR_IDX_CTL) begin
                st_nxt.rdata = {1'b0, st_r.ctl};
                st_nxt.rd_ctl = 1'b1;
            end else if (ar_idx == `PTMR_IDX_IE) begin
                st_nxt.rdata[`PTMR_FLAG_BIT] = st_r.ie;
            end else if (ar_idx == `PTMR_IDX_PERIOD) begin
                st_nxt.rdata = st_r.period;
            end else if (ar_idx == `PTMR_IDX_INTEN) begin
                st_nxt.rdata[`PTMR_GIE_BIT] = st_r.global_interrupt_enable;
                st_nxt.rdata[`PTMR_PERIPHERAL_INTERRUPT_ENABLE_BIT] = st_r.peripheral_interrupt_enable;
            end else begin
                st_nxt.rresp = `PTMR_RESP_SLVERR;
            end
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        // One write and one read outstanding at most
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
        // Control top bit simply has no storage
        if (ctl_wr) begin
            st_nxt.ctl = st_r.wdata[6:0];
        end
        // A control or count write in the same cycle suppresses the step
        inc = pre_if.tick && st_r.ctl[`PTMR_RUN_BIT] && !ctl_wr && !cnt_wr;
        if (cnt_wr) begin
            st_nxt.count = st_r.wdata;
        end else if (inc) begin
            if (st_r.count == st_r.period) begin
                st_nxt.count = 8'h00;
                st_nxt.ssp_tick = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 8'h01;
            end
        end
        // Hardware set wins over a software clear
        if (post_if.tick) begin
            st_nxt.flag = 1'b1;
        end
        st_nxt.irq = st_r.flag && st_r.ie && st_r.peripheral_interrupt_enable && st_r.global_interrupt_enable;
    end
    // State register; reset also clears both scalers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.period <= `PTMR_PERIOD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ssp_match;
        inc && st_r.count == st_r.period |=> ssp_shift_tick && st_r.count == 8'h00;
    endproperty
    a_ssp_match: assert property (p_ssp_match)
        else $error("match not passed to serial port");
    property p_halt;
        !st_r.ctl[`PTMR_RUN_BIT] && !cnt_wr |=> $stable(st_r.count);
    endproperty
    a_halt: assert property (p_halt)
        else $error("count moved while halted");
    property p_ctl_top;
        s_axi_rvalid && st_r.rd_ctl |-> !s_axi_rdata[`PTMR_CTL_TOP_BIT];
    endproperty
    a_ctl_top: assert property (p_ctl_top)
        else $error("control top bit read as one");
    property p_step;
        inc && st_r.count != st_r.period |=> st_r.count == $past(st_r.count) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("count did not step by one");
    property p_flag_set;
        post_if.tick |=> st_r.flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("postscaled match lost");
    property p_ctl_keeps_count;
        ctl_wr |=> $stable(st_r.count) && !pre_if.tick;
    endproperty
    a_ctl_keeps_count: assert property (p_ctl_keeps_count)
        else $error("control write disturbed count or prescaler");
    property p_irq;
        st_r.flag && st_r.ie && st_r.peripheral_interrupt_enable && st_r.global_interrupt_enable |=> irq_req;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled flag gave no request");
    property p_irq_gate;
        irq_req |-> $past(st_r.flag && st_r.ie && st_r.peripheral_interrupt_enable && st_r.global_interrupt_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request without all enables");
endmodule

// *** ptmr_top_end.sv ***
`timescale 1ns/1ns

// *** ptmr_top_test.sv ***
`timescale 1ns/1ns
`include "ptmr_defines.svh"
module ptmr_top_test;
    import ptmr_pkg::*;
    // ****************************************
    // Byte addresses of the registers
    // ****************************************
    localparam logic [11:0] A_INTEN = 12'h02C; // Global and peripheral enables
    localparam logic [11:0] A_FLAGS = 12'h030; // Peripheral flags
    localparam logic [11:0] A_COUNT = 12'h044; // Timer count
    localparam logic [11:0] A_CTL = 12'h048;   // Timer control
    localparam logic [11:0] A_IE = 12'h230;    // Peripheral enables
    localparam logic [11:0] A_PER = 12'h248;   // Timer period
    localparam logic [11:0] A_NONE = 12'h3FC;  // Unmapped word
    logic aclk, aresetn; // Clock and reset
    logic [11:0] s_axi_awaddr, s_axi_araddr; // Addresses
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // Write handshakes
    logic [31:0] s_axi_wdata, s_axi_rdata; // Data
    logic [3:0] s_axi_wstrb; // Strobes
    logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // Handshakes
    logic s_axi_rvalid, s_axi_rready; // Read handshake
    logic ssp_shift_tick, irq_req; // Timer outputs
    int num_errors = 0; // Mismatches
    int total_checks = 0; // Comparisons
    ptmr_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ssp_shift_tick(ssp_shift_tick), .irq_req(irq_req));
    // ****************************************
    // Clock, 20 ns period
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    // Compare with case inequality so unknowns fail
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One write; each channel released at its own handshake edge
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        s_axi_bready <= 1'b0;
        // A response that never came counts as a mismatch
        if (s_axi_bvalid !== 1'b1) begin
            num_errors++;
        end
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        // Idle edge so the next call never reassigns bready in this step
        @(posedge aclk);
    endtask
    // One read; data taken at the edge where rvalid is seen
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // A read answer that never came counts as a mismatch
        if (s_axi_rvalid !== 1'b1) begin
            num_errors++;
        end
        // Idle edge so the next call never reassigns rready in this step
        @(posedge aclk);
    endtask
    // Read and compare data with an OKAY response
    task automatic read_check(input string nm, input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(nm, d, {24'h000000, e});
        check("rresp", {30'h0, r}, {30'h0, `PTMR_RESP_OKAY});
    endtask
    // Cycles between two raw match pulses; a wide pulse gives a gap of one
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (ssp_shift_tick !== 1'b1 && n < 3000);
        gap = 0;
        do begin
            @(posedge aclk);
            gap++;
        end while (ssp_shift_tick !== 1'b1 && gap < 3000);
    endtask
    // ****************************************
    // Watchdog, well beyond the expected run
    // ****************************************
    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        close_out();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int g, k, n, pre;
        int codes[4] = '{0, 1, 7, 15}; // Postscale codes tried
        logic [11:0] ra[6] = '{A_INTEN, A_FLAGS, A_COUNT, A_CTL, A_IE, A_PER};
        logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `PTMR_PERIOD_RST};
        aresetn = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Readies come up one edge after release
        repeat (2) @(posedge aclk);
        // Reset values of every register
        for (int i = 0; i < 6; i++) begin
            read_check("reset_value", ra[i], rv[i]);
        end
        // Halted timer keeps a loaded count
        axi_write(A_COUNT, 8'h2A, 4'h1, `PTMR_RESP_OKAY);
        repeat (100) @(posedge aclk);
        read_check("count_halted", A_COUNT, 8'h2A);
        // Control write keeps count; top bit absent
        axi_write(A_CTL, 8'hFB, 4'h1, `PTMR_RESP_OKAY);
        read_check("count_after_ctl", A_COUNT, 8'h2A);
        read_check("ctl_readback", A_CTL, 8'h7B);
        axi_write(A_CTL, 8'h80, 4'h1, `PTMR_RESP_OKAY);
        read_check("ctl_top_bit", A_CTL, 8'h00);
        // Strobe off: write is dropped but answered
        axi_write(A_COUNT, 8'h55, 4'h0, `PTMR_RESP_OKAY);
        read_check("count_no_strobe", A_COUNT, 8'h2A);
        // Unmapped word refused both ways
        axi_write(A_NONE, 8'h11, 4'h1, `PTMR_RESP_SLVERR);
        axi_read(A_NONE, d, r);
        check("unmapped_data", d, 32'h00000000);
        check("unmapped_resp", {30'h0, r}, {30'h0, `PTMR_RESP_SLVERR});
        // Match spacing for every prescale code, period 2
        axi_write(A_PER, 8'h02, 4'h1, `PTMR_RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            pre = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
            axi_write(A_CTL, 8'h04 | 8'(c), 4'h1, `PTMR_RESP_OKAY);
            tick_gap(g);
            check("match_gap", 32'(g), 32'(3 * 4 * pre));
        end
        // Postscaled flag after code plus one matches, period 1
        axi_write(A_PER, 8'h01, 4'h1, `PTMR_RESP_OKAY);
        axi_write(A_INTEN, 8'hC0, 4'h1, `PTMR_RESP_OKAY);
        axi_write(A_IE, 8'h02, 4'h1, `PTMR_RESP_OKAY);
        foreach (codes[i]) begin
            // Halt first so no match is in flight across the clear
            axi_write(A_CTL, 8'h00, 4'h1, `PTMR_RESP_OKAY);
            axi_write(A_FLAGS, 8'h00, 4'h1, `PTMR_RESP_OKAY);
            axi_write(A_CTL, {1'b0, 4'(codes[i]), 3'b100}, 4'h1, `PTMR_RESP_OKAY);
            k = 0;
            n = 0;
            do begin
                @(posedge aclk);
                n++;
                if (ssp_shift_tick === 1'b1) begin
                    k++;
                end
            end while (irq_req !== 1'b1 && n < 3000);
            check("matches_to_flag", 32'(k), 32'(codes[i] + 1));
        end
        // Flag sticks once the timer halts; request drops without IE or the peripheral enable
        axi_write(A_CTL, 8'h00, 4'h1, `PTMR_RESP_OKAY);
        repeat (40) @(posedge aclk);
        read_check("flag_sticky", A_FLAGS, 8'h02);
        check("irq_all_enabled", {31'h0, irq_req}, 32'h1);
        axi_write(A_IE, 8'h00, 4'h1, `PTMR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("irq_no_ie", {31'h0, irq_req}, 32'h0);
        axi_write(A_IE, 8'h02, 4'h1, `PTMR_RESP_OKAY);
        axi_write(A_INTEN, 8'h80, 4'h1, `PTMR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("irq_no_peripheral_interrupt_enable", {31'h0, irq_req}, 32'h0);
        axi_write(A_INTEN, 8'hC0, 4'h1, `PTMR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("irq_back", {31'h0, irq_req}, 32'h1);
        axi_write(A_FLAGS, 8'h00, 4'h1, `PTMR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("irq_cleared", {31'h0, irq_req}, 32'h0);
        read_check("flag_cleared", A_FLAGS, 8'h00);
        close_out();
    end
endmodule
